/* pkg/thermal_gpio_pkg.sv */
// Purpose: Shared constants for the thermal timer, GPIO and event outputs
// Assumes: Avalon-MM word addresses equal the register indices below
// Notes:   Byte address of a register is four times its index
package thermal_gpio_pkg;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_GPIO_CONFIG_LOW     = 8'h09;
  localparam logic [7:0] IDX_GPIO_CONFIG_HIGH    = 8'h0A;
  localparam logic [7:0] IDX_THERMAL_WINDOW_CFG  = 8'h0D;
  localparam logic [7:0] IDX_ALARM_ONE_CONFIG    = 8'h0E;
  localparam logic [7:0] IDX_ALARM_TWO_CONFIG    = 8'h0F;
  localparam logic [7:0] IDX_GPIO_ALERT_MASK     = 8'h36;
  localparam logic [7:0] IDX_EVENT_OUT_ONE_MASK  = 8'h37;
  localparam logic [7:0] IDX_EVENT_OUT_TWO_MASK  = 8'h38;
  localparam logic [7:0] IDX_EVENT_OUT_CONTROL   = 8'h39;
  localparam logic [7:0] IDX_ALARM_ALERT_MASK    = 8'h3A;
  localparam logic [7:0] IDX_ALARM_ONE_LIMIT     = 8'h80;
  localparam logic [7:0] IDX_ALARM_TWO_LIMIT     = 8'h81;
  localparam logic [7:0] IDX_ALARM_ONE_ON_TIME   = 8'hAE;
  localparam logic [7:0] IDX_ALARM_TWO_ON_TIME   = 8'hAF;
  localparam logic [7:0] IDX_HOST_THERMAL_STAT2  = 8'hB9;
  localparam logic [7:0] IDX_GPIO_PIN_STATUS     = 8'hBF;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ALARM_TIMER_ENABLE_BIT = 0;   // In each alarm config
  localparam int ALARM_ZONE_LSB         = 1;   // Zone field [4:1]
  localparam int ALARM_ZONE_MSB         = 4;
  localparam int WIN_ONE_LSB            = 2;   // Window code [4:2]
  localparam int WIN_TWO_LSB            = 5;   // Window code [7:5]
  localparam int GPIO_DIR_LSB           = 0;   // Direction [3:0]
  localparam int GPIO_POL_LSB           = 4;   // Polarity [7:4]
  localparam int EDO_VOLT_BIT           = 7;
  localparam int EDO_THERMAL_ALARM_PIN_BIT          = 6;
  localparam int EDO_FAN_BIT            = 5;
  localparam int EDO_ENABLE_LSB         = 0;   // Control [1:0]
  localparam int EDO_LATCH_LSB          = 2;   // Control [3:2]
  localparam int STAT_ASSERT_LSB        = 0;   // Thermal status [1:0]
  localparam int STAT_STATE_LSB         = 2;   // Thermal status [3:2]
  localparam int STAT_PCT_LSB           = 4;   // Thermal status [5:4]

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] LIMIT_NEVER   = 8'hFF;
  localparam logic [7:0] LIMIT_FIRST   = 8'h00;
  localparam logic [7:0] STEPS_LAST    = 8'hFF;  // 256 samples per window
  localparam logic [2:0] WIN_CODE_MAX  = 3'h5;   // 101..111 all mean 8 s

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned WINDOW_BASE_MS  = 250;
  localparam int unsigned WINDOW_BASE_CYC = WINDOW_BASE_MS * (CLK_HZ / 1000);
  localparam int unsigned STEPS_PER_WIN   = 256;

endpackage

/* src/thermal_timer_gpio_event_outputs.sv */
// Purpose: Thermal alarm timers, open-drain GPIO and event outputs
// Assumes: All pin inputs synchronous to sys_clk; Avalon-MM word address
// Notes:   Open-drain pins only ever pull low; enables carry the level
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Alarm pin monitored only while its timer-enable bit 0 is one.
// - Assert status bit is one while the alarm input is held low.
// - State status bit sets on every falling edge of the alarm input.
// - Window code: channel one bits 4..2, channel two bits 7..5.
// - Codes 000..100 give 0.25 s..4 s; 101, 110, 111 give 8 s.
// - On-time register holds running asserted fraction of window.
// - On-time above limit sets percent flag and alert unless masked.
// - Limit zero alerts on first assertion; all ones never alerts.
// - Limit is eight bits, linear, all ones equals whole window.
// - On-time compared with limit as each window ends.
// - Enabled alarm with zone bits 4..1 set also drives the pin.
// - Eight open-drain pins; 1-4 trigger, 5-6 event outputs, 7-8 plain.
// - Direction bit one makes pin output, zero makes it input.
// - Polarity bit one means active high, zero active low.
// - Input pin status is read-only and shows asserted level.
// - Output pin status is writable; one drives asserted level.
// - Set GPIO mask bit keeps that pin away from the alert.
// - Output pins are masked from the alert automatically.
// - Two event mask registers let pins 1-4 trigger either output.
// - Mask bits 7,6,5 gate voltage, thermal and fan fault events.
// - Mask bits 0-3 exclude pins 1-4; output is OR of the rest.
module thermal_timer_gpio_event_outputs #(
  parameter int unsigned WINDOW_BASE_CYCLES =
    thermal_gpio_pkg::WINDOW_BASE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  alarmPinInN,
  output logic      [1:0]  alarmPinOut,
  output logic      [1:0]  alarmPinOe,
  input  wire logic [1:0]  overTemp,
  input  wire logic [7:0]  gpioIn,
  output logic      [7:0]  gpioOut,
  output logic      [7:0]  gpioOe,
  input  wire logic        voltFault,
  input  wire logic        fanFault,
  output logic             alert
);
  import thermal_gpio_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       cfgLo;
    logic [7:0]       cfgHi;
    logic [7:0]       winCfg;
    logic [1:0][7:0]  almCfg;
    logic [7:0]       gpioMask;
    logic [1:0][7:0]  edoMask;
    logic [7:0]       edoCtl;
    logic [7:0]       almMask;
    logic [1:0][7:0]  lim;
    logic [7:0]       gpioWr;
    logic [1:0]       almPrev;
    logic [1:0]       stateFlag;
    logic [1:0]       pctFlag;
    logic [1:0][7:0]  onTime;
    logic [1:0][7:0]  stepIdx;
    logic [1:0][31:0] stepCnt;
    logic [1:0]       event_driven_output;
    logic             alert;
    logic [7:0]       gpioOe;
    logic [1:0]       almOe;
    logic             waitReq;
    logic [7:0]       rdata;
  } state_t;

  state_t q;
  state_t d;

  // Sample step; never below one cycle even for tiny test windows
  localparam int unsigned SLICE_RAW = WINDOW_BASE_CYCLES / STEPS_PER_WIN;
  localparam logic [31:0] SLICE_CYC =
    (SLICE_RAW == 0) ? 32'h0000_0001 : 32'(SLICE_RAW);

  // ---------------------------------------------------------------
  // Decoded views of the registers
  // ---------------------------------------------------------------
  logic [1:0]       almEn;
  logic [1:0]       almAssert;
  logic [1:0][2:0]  winCode;
  logic [1:0][31:0] stepLen;
  logic [7:0]       dir;
  logic [7:0]       pol;
  logic [1:0]       edoUse;
  logic [7:0]       effDir;
  logic [7:0]       gpioAsserted;
  logic [7:0]       gpioStat;
  logic [1:0]       edoEvent;
  logic             busReq;
  logic             busWr;
  logic [7:0]       wdat;

  // Alarm pins only count when their timer is enabled
  assign almEn = {q.almCfg[1][ALARM_TIMER_ENABLE_BIT],
                  q.almCfg[0][ALARM_TIMER_ENABLE_BIT]};
  assign almAssert = almEn & ~alarmPinInN;

  // Window codes, clipped so 101..111 all pick the 8 s window
  assign winCode[0] = q.winCfg[WIN_ONE_LSB +: 3];
  assign winCode[1] = q.winCfg[WIN_TWO_LSB +: 3];
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      stepLen[c] = (winCode[c] > WIN_CODE_MAX) ?
                   (SLICE_CYC << WIN_CODE_MAX) :
                   (SLICE_CYC << winCode[c]);
    end
  end

  // Pins 5 and 6 turn into outputs when their event output is on
  assign dir    = {q.cfgHi[GPIO_DIR_LSB +: 4], q.cfgLo[GPIO_DIR_LSB +: 4]};
  assign pol    = {q.cfgHi[GPIO_POL_LSB +: 4], q.cfgLo[GPIO_POL_LSB +: 4]};
  assign edoUse = q.edoCtl[EDO_ENABLE_LSB +: 2];
  assign effDir = dir | {2'b00, edoUse, 4'h0};
  assign gpioAsserted = ~(gpioIn ^ pol);

  // Inputs show live level, outputs show stored or event value
  always_comb begin
    gpioStat = (effDir & q.gpioWr) | (~effDir & gpioAsserted);
    for (int k = 0; k < 2; k++) begin
      if (edoUse[k]) begin
        gpioStat[4 + k] = q.event_driven_output[k];
      end
    end
  end

  // Event sources for each output, a set mask bit ignores the source
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      edoEvent[k] = (|(gpioAsserted[3:0] & ~q.edoMask[k][3:0]))
                  | (voltFault & ~q.edoMask[k][EDO_VOLT_BIT])
                  | ((|almAssert) & ~q.edoMask[k][EDO_THERMAL_ALARM_PIN_BIT])
                  | (fanFault & ~q.edoMask[k][EDO_FAN_BIT]);
    end
  end

  assign busReq = avs_read | avs_write;
  assign busWr  = avs_write & ~q.waitReq & avs_byteenable[0];
  assign wdat   = avs_writedata[7:0];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] onNext;
    logic       cfgTouch;
    onNext   = 8'h00;
    cfgTouch = 1'b0;
    d = q;

    // Waitrequest drops for exactly one cycle per request
    d.waitReq = ~(busReq & q.waitReq);
    if (avs_read && q.waitReq) begin
      case (avs_address)
        IDX_GPIO_CONFIG_LOW:    d.rdata = q.cfgLo;
        IDX_GPIO_CONFIG_HIGH:   d.rdata = q.cfgHi;
        IDX_THERMAL_WINDOW_CFG: d.rdata = q.winCfg;
        IDX_ALARM_ONE_CONFIG:   d.rdata = q.almCfg[0];
        IDX_ALARM_TWO_CONFIG:   d.rdata = q.almCfg[1];
        IDX_GPIO_ALERT_MASK:    d.rdata = q.gpioMask;
        IDX_EVENT_OUT_ONE_MASK: d.rdata = q.edoMask[0];
        IDX_EVENT_OUT_TWO_MASK: d.rdata = q.edoMask[1];
        IDX_EVENT_OUT_CONTROL:  d.rdata = q.edoCtl;
        IDX_ALARM_ALERT_MASK:   d.rdata = q.almMask;
        IDX_ALARM_ONE_LIMIT:    d.rdata = q.lim[0];
        IDX_ALARM_TWO_LIMIT:    d.rdata = q.lim[1];
        IDX_ALARM_ONE_ON_TIME:  d.rdata = q.onTime[0];
        IDX_ALARM_TWO_ON_TIME:  d.rdata = q.onTime[1];
        IDX_HOST_THERMAL_STAT2: d.rdata = {2'b00, q.pctFlag,
                                           q.stateFlag, almAssert};
        IDX_GPIO_PIN_STATUS:    d.rdata = gpioStat;
        default:                d.rdata = 8'h00;
      endcase
    end

    // Register writes; flags use write-one-to-clear
    if (busWr) begin
      case (avs_address)
        IDX_GPIO_CONFIG_LOW:    d.cfgLo = wdat;
        IDX_GPIO_CONFIG_HIGH: begin
          d.cfgHi  = wdat;
          cfgTouch = 1'b1;
        end
        IDX_THERMAL_WINDOW_CFG: d.winCfg = wdat;
        IDX_ALARM_ONE_CONFIG:   d.almCfg[0] = wdat;
        IDX_ALARM_TWO_CONFIG:   d.almCfg[1] = wdat;
        IDX_GPIO_ALERT_MASK:    d.gpioMask = wdat;
        IDX_EVENT_OUT_ONE_MASK: begin
          d.edoMask[0] = wdat;
          cfgTouch     = 1'b1;
        end
        IDX_EVENT_OUT_TWO_MASK: begin
          d.edoMask[1] = wdat;
          cfgTouch     = 1'b1;
        end
        IDX_EVENT_OUT_CONTROL: begin
          d.edoCtl = wdat;
          cfgTouch = 1'b1;
        end
        IDX_ALARM_ALERT_MASK:   d.almMask = wdat;
        IDX_ALARM_ONE_LIMIT:    d.lim[0] = wdat;
        IDX_ALARM_TWO_LIMIT:    d.lim[1] = wdat;
        IDX_HOST_THERMAL_STAT2: begin
          d.stateFlag = q.stateFlag & ~wdat[STAT_STATE_LSB +: 2];
          d.pctFlag   = q.pctFlag & ~wdat[STAT_PCT_LSB +: 2];
        end
        IDX_GPIO_PIN_STATUS:    d.gpioWr = wdat;
        default: ;
      endcase
    end

    // Alarm channels; hardware sets come after clears so a set wins
    d.almPrev = alarmPinInN;
    for (int c = 0; c < 2; c++) begin
      if (almEn[c] && q.almPrev[c] && !alarmPinInN[c]) begin
        d.stateFlag[c] = 1'b1;
      end
      if (q.lim[c] == LIMIT_FIRST && almAssert[c]) begin
        d.pctFlag[c] = 1'b1;
      end
      if (!almEn[c]) begin
        d.stepCnt[c] = 32'h0000_0000;
        d.stepIdx[c] = 8'h00;
        d.onTime[c]  = 8'h00;
      end else if (q.stepCnt[c] >= stepLen[c] - 32'h0000_0001) begin
        // One sample per step, 256 steps make one window
        d.stepCnt[c] = 32'h0000_0000;
        onNext = q.onTime[c];
        if (almAssert[c] && onNext != 8'hFF) begin
          onNext = onNext + 8'h01;
        end
        if (q.stepIdx[c] == STEPS_LAST) begin
          if (onNext > q.lim[c]) begin
            d.pctFlag[c] = 1'b1;
          end
          d.onTime[c]  = 8'h00;
          d.stepIdx[c] = 8'h00;
        end else begin
          d.onTime[c]  = onNext;
          d.stepIdx[c] = q.stepIdx[c] + 8'h01;
        end
      end else begin
        d.stepCnt[c] = q.stepCnt[c] + 32'h0000_0001;
      end
      // Pin pulls low on over-temperature when zone bits enable output
      d.almOe[c] = almEn[c]
                 & (|q.almCfg[c][ALARM_ZONE_MSB:ALARM_ZONE_LSB])
                 & overTemp[c];
    end

    // Event outputs; a GPIO config high, event mask or event control write re-evaluates a latched output
    for (int k = 0; k < 2; k++) begin
      if (!edoUse[k]) begin
        d.event_driven_output[k] = 1'b0;
      end else if (q.edoCtl[EDO_LATCH_LSB + k] && !cfgTouch) begin
        d.event_driven_output[k] = q.event_driven_output[k] | edoEvent[k];
      end else begin
        d.event_driven_output[k] = edoEvent[k];
      end
    end

    // Open drain: pull low unless the wanted level is high
    for (int i = 0; i < 8; i++) begin
      d.gpioOe[i] = effDir[i] & ~(gpioStat[i] ? pol[i] : ~pol[i]);
    end

    // Output pins never reach the alert, whatever their mask
    d.alert = (|(q.pctFlag & ~q.almMask[1:0]))
            | (|(gpioAsserted & ~effDir & ~q.gpioMask));
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q         <= '0;
      q.almPrev <= 2'b11;
      q.waitReq <= 1'b1;
      q.lim     <= {LIMIT_NEVER, LIMIT_NEVER};
    end else begin
      q <= d;
    end
  end

  assign avs_readdata    = {24'h00_0000, q.rdata};
  assign avs_waitrequest = q.waitReq;
  assign alarmPinOut     = 2'b00;
  assign alarmPinOe      = q.almOe;
  assign gpioOut         = 8'h00;
  assign gpioOe          = q.gpioOe;
  assign alert           = q.alert;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_bus_one_wait: assert property (
    (busReq && q.waitReq) |=> (!avs_waitrequest ##1 avs_waitrequest))
    else $error("waitrequest not low for exactly one cycle");

  chk_disabled_idle: assert property (
    !almEn[0] |=> (q.onTime[0] == 8'h00 && q.stepIdx[0] == 8'h00))
    else $error("disabled alarm channel still timing");

  chk_fall_sets_state: assert property (
    (almEn[1] && q.almPrev[1] && !alarmPinInN[1]) |=> q.stateFlag[1])
    else $error("falling edge did not set state flag");

  chk_limit_never: assert property (
    (q.lim[0] == LIMIT_NEVER && !q.pctFlag[0] && !busWr)
      |=> !q.pctFlag[0])
    else $error("limit all ones raised percent flag");

  chk_limit_first: assert property (
    (q.lim[1] == LIMIT_FIRST && almAssert[1]) |=> q.pctFlag[1])
    else $error("limit zero missed first assertion");

  chk_window_restart: assert property (
    (almEn[0] && q.stepIdx[0] == STEPS_LAST
      && q.stepCnt[0] >= stepLen[0] - 32'h0000_0001)
      |=> (q.onTime[0] == 8'h00 && q.stepIdx[0] == 8'h00))
    else $error("on-time not restarted at window end");

  chk_pct_alert: assert property (
    (q.pctFlag[0] && !q.almMask[0]) |=> alert)
    else $error("unmasked percent flag gave no alert");

  chk_output_masked: assert property (
    (effDir == 8'hFF && q.pctFlag == 2'b00 && !busWr) |=> !alert)
    else $error("output pin reached the alert");

  chk_input_no_drive: assert property (
    (effDir[7] == 1'b0) |=> !gpioOe[7])
    else $error("input pin driven");

  chk_edo_holds: assert property (
    (q.event_driven_output[0] && edoUse[0] && q.edoCtl[EDO_LATCH_LSB] && !busWr)
      |=> q.event_driven_output[0])
    else $error("latched event output dropped");

  chk_state_set_wins: assert property (
    (almEn[0] && q.almPrev[0] && !alarmPinInN[0]) |=> q.stateFlag[0])
    else $error("state flag lost to a same-cycle clear");

  chk_alarm_io_off: assert property (
    !almEn[0] |=> !alarmPinOe[0])
    else $error("disabled alarm pin driven");

  chk_edo_unused: assert property (
    !edoUse[1] |=> !q.event_driven_output[1])
    else $error("unused event output active");

endmodule

`default_nettype wire

/* tb/pin_source_model.sv */
// Purpose: Pin-side model of trip sensors and interrupt sources
// Assumes: Every alarm and GPIO line is open-drain with a pull-up
// Notes:   slow delays what the sources drive by one clock
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
  input  wire logic       sys_clk,
  input  wire logic       slow,
  input  wire logic [1:0] alarmDriveN,
  input  wire logic [7:0] gpioDrive,
  input  wire logic [1:0] alarmPinOe,
  input  wire logic [7:0] gpioOe,
  output logic      [1:0] alarmPinInN,
  output logic      [7:0] gpioIn
);
  logic [1:0] alarmLagN;
  logic [7:0] gpioLag;

  // Lagged copy, a sluggish sensor seen one clock late
  always_ff @(posedge sys_clk) begin
    alarmLagN <= alarmDriveN;
    gpioLag   <= gpioDrive;
  end

  // Wired-AND: released lines float up, any sink wins
  assign alarmPinInN = (slow ? alarmLagN : alarmDriveN) & ~alarmPinOe;
  assign gpioIn      = (slow ? gpioLag : gpioDrive) & ~gpioOe;
endmodule
`default_nettype wire

/* tb/thermal_timer_gpio_event_outputs_tb_top.sv */
// Purpose: Self-checking bench for the thermal timer, GPIO and event block
// Assumes: Base of 256 cycles, so one timer step is one clock at window code 000
// Notes:   Random draws come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module thermal_timer_gpio_event_outputs_tb_top;
  import thermal_gpio_pkg::*;
  localparam int unsigned BASE = 256;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  alarmPinInN, alarmPinOut, alarmPinOe;
  logic [1:0]  overTemp = 2'b00;
  logic [1:0]  alarmDriveN = 2'b11;
  logic [7:0]  gpioIn, gpioOut, gpioOe;
  logic [7:0]  gpioDrive = 8'hFF;
  logic        voltFault = 1'b0;
  logic        fanFault = 1'b0;
  logic        alert;
  logic        slow = 1'b0;
  logic [7:0]  rd, m1, m2, pol;
  logic [15:0] cfg;
  logic [3:0]  asrt;
  int          errors = 0;
  int          comparisons = 0;
  int          seed = 28;
  int          p;

  always #10 sys_clk = ~sys_clk;

  thermal_timer_gpio_event_outputs #(.WINDOW_BASE_CYCLES(BASE)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .alarmPinInN(alarmPinInN), .alarmPinOut(alarmPinOut),
    .alarmPinOe(alarmPinOe), .overTemp(overTemp), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .voltFault(voltFault),
    .fanFault(fanFault), .alert(alert));

  pin_source_model src_u (
    .sys_clk(sys_clk), .slow(slow), .alarmDriveN(alarmDriveN),
    .gpioDrive(gpioDrive), .alarmPinOe(alarmPinOe), .gpioOe(gpioOe),
    .alarmPinInN(alarmPinInN), .gpioIn(gpioIn));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic busCycle(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check(n < 64, 1'b1, "bus answer");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busCycle(1'b1, a, d);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e, string s);
    busCycle(1'b0, a, 8'h00);
    check(rd, e, s);
  endtask

  function automatic int unsigned win(input logic [2:0] c);
    return BASE << ((c > WIN_CODE_MAX) ? WIN_CODE_MAX : c);
  endfunction

  function automatic logic oeFor(input logic v, input logic pl);
    return v != pl;
  endfunction

  function automatic logic edoFor(input logic [3:0] a, input logic [7:0] m);
    return (|(a & ~m[3:0])) | (voltFault & ~m[7]) | (fanFault & ~m[5]);
  endfunction

  // Full-window assertion with limit 0xFE: alert lands at window end
  task automatic windowRun(input logic ch, input logic [2:0] code);
    int n;
    int unsigned w;
    logic [7:0] ca;
    w = win(code);
    ca = ch ? IDX_ALARM_TWO_CONFIG : IDX_ALARM_ONE_CONFIG;
    wr(ca, 8'h00);
    wr(IDX_HOST_THERMAL_STAT2, 8'hFF);
    wr(IDX_THERMAL_WINDOW_CFG, ch ? {code, 5'h00} : {3'h0, code, 2'h0});
    wr(ch ? IDX_ALARM_TWO_LIMIT : IDX_ALARM_ONE_LIMIT, 8'hFE);
    alarmDriveN <= ch ? 2'b01 : 2'b10;
    wr(ca, 8'h01);
    n = 0;
    while (alert !== 1'b1 && n < w + 64) begin
      @(posedge sys_clk);
      n++;
    end
    check(n > w - w / 16 && n <= w + 8, 1'b1, "window length");
    busCycle(1'b0, IDX_HOST_THERMAL_STAT2, 8'h00);
    check(rd[5:4], ch ? 2'b10 : 2'b01, "percent flag");
    alarmDriveN <= 2'b11;
    wr(ca, 8'h00);
    wr(IDX_HOST_THERMAL_STAT2, 8'hFF);
  endtask

  // Three pulses, each in its own window, against limit 0x20 or 0x00 set by the caller
  task automatic pulseRun(input int len, input logic exp);
    wr(IDX_HOST_THERMAL_STAT2, 8'hFF);
    repeat (3) begin
      alarmDriveN <= 2'b10;
      cyc(len);
      alarmDriveN <= 2'b11;
      cyc(300);
    end
    check(alert, exp, "pulse limit");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdChk(IDX_ALARM_ONE_LIMIT, LIMIT_NEVER, "limit1 reset");
    rdChk(IDX_ALARM_TWO_LIMIT, LIMIT_NEVER, "limit2 reset");
    rdChk(IDX_GPIO_CONFIG_LOW, REG_RESET, "gpio cfg reset");
    wr(8'h50, 8'h5A);
    rdChk(8'h50, 8'h00, "unmapped");
    avs_byteenable <= 4'h0;
    wr(IDX_ALARM_ONE_LIMIT, 8'h12);
    avs_byteenable <= 4'hF;
    rdChk(IDX_ALARM_ONE_LIMIT, LIMIT_NEVER, "byteenable off");
    done("registers");

    alarmDriveN <= 2'b10;
    cyc(3);
    rdChk(IDX_HOST_THERMAL_STAT2, 8'h00, "disabled pin");
    alarmDriveN <= 2'b11;
    wr(IDX_ALARM_ONE_CONFIG, 8'h01);
    alarmDriveN <= 2'b10;
    cyc(3);
    rdChk(IDX_HOST_THERMAL_STAT2, 8'h05, "assert+state");
    alarmDriveN <= 2'b11;
    cyc(3);
    rdChk(IDX_HOST_THERMAL_STAT2, 8'h04, "state sticky");
    wr(IDX_HOST_THERMAL_STAT2, 8'h0C);
    for (int i = 0; i < 6; i++) begin
      cfg[7:0] = (i == 0) ? 8'h03 : (8'($random(seed)) & 8'h1F);
      wr(IDX_ALARM_ONE_CONFIG, cfg[7:0]);
      overTemp <= 2'b01;
      cyc(3);
      check(alarmPinOe[0], cfg[0] & (|cfg[4:1]), "io mode");
      overTemp <= 2'b00;
      wr(IDX_ALARM_ONE_CONFIG, 8'h00);
    end
    wr(IDX_HOST_THERMAL_STAT2, 8'hFF);
    done("alarm status");

    for (int c = 0; c < 8; c++) windowRun(1'b0, 3'(c));
    windowRun(1'b1, 3'h1);
    done("windows");

    wr(IDX_THERMAL_WINDOW_CFG, 8'h00);
    wr(IDX_ALARM_ONE_LIMIT, 8'h20);
    wr(IDX_ALARM_ONE_CONFIG, 8'h01);
    pulseRun(30, 1'b0);
    pulseRun(80, 1'b1);
    wr(IDX_ALARM_ONE_LIMIT, LIMIT_FIRST);
    pulseRun(1, 1'b1);
    wr(IDX_ALARM_ALERT_MASK, 8'h01);
    pulseRun(4, 1'b0);
    wr(IDX_ALARM_ALERT_MASK, 8'h00);
    wr(IDX_ALARM_ONE_LIMIT, LIMIT_NEVER);
    wr(IDX_HOST_THERMAL_STAT2, 8'hFF);
    alarmDriveN <= 2'b10;
    cyc(600);
    check(alert, 1'b0, "limit never");
    alarmDriveN <= 2'b11;
    wr(IDX_ALARM_ONE_CONFIG, 8'h00);
    wr(IDX_HOST_THERMAL_STAT2, 8'hFF);
    done("limits");

    for (int i = 0; i < 12; i++) begin
      p = $unsigned($random(seed)) % 8;
      pol = 8'($random(seed));
      cfg = 16'h0000;
      cfg[(p / 4) * 8 + p % 4] = 1'b1;
      cfg[(p / 4) * 8 + p % 4 + 4] = pol[0];
      wr(IDX_GPIO_CONFIG_LOW, cfg[7:0]);
      wr(IDX_GPIO_CONFIG_HIGH, cfg[15:8]);
      wr(IDX_GPIO_PIN_STATUS, 8'(pol[1]) << p);
      cyc(3);
      check(gpioOe[p], oeFor(pol[1], pol[0]), "out level");
      check(alert, 1'b0, "out masked");
      rdChk(IDX_GPIO_PIN_STATUS, 8'(pol[1]) << p, "out status");
    end
    wr(IDX_GPIO_CONFIG_LOW, 8'h0F);
    wr(IDX_GPIO_CONFIG_HIGH, 8'h0F);
    wr(IDX_GPIO_PIN_STATUS, 8'hFF);
    cyc(3);
    check(gpioOe, 8'hFF, "all pulled");
    check(alert, 1'b0, "all outputs");
    done("gpio out");

    slow <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      gpioDrive <= (i == 0) ? 8'h00 : 8'($random(seed));
      cfg = 16'($random(seed)) & 16'hF0F0;
      m1 = (i == 0) ? 8'h00 : 8'($random(seed));
      wr(IDX_GPIO_CONFIG_LOW, cfg[7:0]);
      wr(IDX_GPIO_CONFIG_HIGH, cfg[15:8]);
      wr(IDX_GPIO_ALERT_MASK, m1);
      wr(IDX_GPIO_PIN_STATUS, 8'hFF);
      cyc(4);
      pol = {cfg[15:12], cfg[7:4]};
      rdChk(IDX_GPIO_PIN_STATUS, ~(gpioDrive ^ pol), "in status");
      check(alert, |(~(gpioDrive ^ pol) & ~m1), "gpio alert");
    end
    slow <= 1'b0;
    done("gpio in");

    wr(IDX_GPIO_CONFIG_LOW, 8'h00);
    wr(IDX_GPIO_CONFIG_HIGH, 8'h00);
    wr(IDX_EVENT_OUT_CONTROL, 8'h03);
    for (int i = 0; i < 16; i++) begin
      m1 = 8'($random(seed));
      m2 = 8'($random(seed));
      asrt = 4'($random(seed));
      voltFault <= 1'($random(seed));
      fanFault <= 1'($random(seed));
      gpioDrive <= {4'hF, ~asrt};
      wr(IDX_EVENT_OUT_ONE_MASK, m1);
      wr(IDX_EVENT_OUT_TWO_MASK, m2);
      cyc(3);
      check(gpioOe[4], edoFor(asrt, m1), "event one");
      check(gpioOe[5], edoFor(asrt, m2), "event two");
    end
    voltFault <= 1'b0;
    fanFault <= 1'b0;
    gpioDrive <= 8'hFF;
    wr(IDX_EVENT_OUT_ONE_MASK, 8'hBF);
    alarmDriveN <= 2'b10;
    wr(IDX_ALARM_ONE_CONFIG, 8'h01);
    cyc(3);
    check(gpioOe[4], 1'b1, "thermal event");
    alarmDriveN <= 2'b11;
    wr(IDX_ALARM_ONE_CONFIG, 8'h00);
    wr(IDX_EVENT_OUT_CONTROL, 8'h0F);
    wr(IDX_EVENT_OUT_ONE_MASK, 8'hEE);
    wr(IDX_EVENT_OUT_TWO_MASK, 8'hFF);
    gpioDrive <= 8'hFE;
    cyc(3);
    gpioDrive <= 8'hFF;
    cyc(3);
    check(gpioOe[5:4], 2'b01, "latched");
    wr(IDX_EVENT_OUT_ONE_MASK, 8'hEE);
    cyc(3);
    check(gpioOe[4], 1'b0, "unlatched");
    check({alarmPinOut, gpioOut}, 10'h000, "pull value");
    done("event outputs");
    report_and_stop();
  end

  // Longest run is about 40k clocks; cut a hang well past that
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
